// [logic/lau_core.v]
`timescale 1ns/1ps
`include "lau_regs.vh"

module lau_core (
  input wire mclk,
  input wire rst,
  input wire turbo_mode,
  input wire carry_in_enable_n,
  input wire prescaler_to_wdt,
  input wire [`LAU_IW-1:0] instr,
  input wire instr_valid,
  input wire [7:0] pc_low_in,
  output wire slot_q,
  output reg [7:0] w_q,
  output reg [7:0] flags_q,
  output reg [7:0] fsel_q,
  output reg pc_wr_q,
  output reg [7:0] pc_wdata_q,
  output reg skip_q,
  output reg wdt_clear_q,
  output reg prescaler_clear_q
);

  // General-purpose file registers; the special addresses are held apart
  reg [7:0] file_mem [0:255];

  reg [`LAU_OP_W-1:0] alu_op;
  reg use_lit;
  reg wr_file;
  reg wr_w;
  reg upd_z;
  reg upd_cdc;
  reg upd_c;
  reg skip_chk;
  reg wdt_clr;
  reg [7:0] file_addr;
  reg [7:0] file_operand;
  reg [7:0] flags_d;
  reg [7:0] fsel_d;
  reg [7:0] w_d;

  wire [7:0] alu_b;
  wire [7:0] alu_res;
  wire alu_c;
  wire alu_dc;
  wire take;
  wire drop;
  wire res_zero;
  wire [4:0] faddr_field;

  // Instruction slots come from the divider; one instruction per slot
  lau_rate_div #(
    .CNT_W(2)
  ) u_div (
    .mclk(mclk),
    .rst(rst),
    .turbo_mode(turbo_mode),
    .slot_q(slot_q)
  );

  // A pending skip eats the next presented instruction as a dead slot
  assign take = slot_q & instr_valid & ~skip_q;
  assign drop = slot_q & instr_valid & skip_q;
  assign faddr_field = instr[`LAU_F_FILE];

  // Operand address: zero field means indirect, high half is banked
  always @* begin
    if ({3'b000, faddr_field} == `LAU_ADDR_INDIRECT) begin
      file_addr = fsel_q;
    end else if (faddr_field[`LAU_F_BANKSEL]) begin
      file_addr = {fsel_q[`LAU_FSEL_BANK], faddr_field};
    end else begin
      file_addr = {3'b000, faddr_field};
    end
  end

  // Operand read; pointer aimed at the indirect slot itself reads zero
  always @* begin
    case (file_addr)
      `LAU_ADDR_INDIRECT: file_operand = `LAU_ZERO8;
      `LAU_ADDR_PC_LOW: file_operand = pc_low_in;
      `LAU_ADDR_FLAGS: file_operand = flags_q;
      `LAU_ADDR_FSEL: file_operand = fsel_q;
      default: file_operand = file_mem[file_addr];
    endcase
  end

  // Opcode decode; encodings outside this unit decode as no operation
  always @* begin
    alu_op = `LAU_OP_PASS;
    use_lit = 1'b0;
    wr_file = 1'b0;
    wr_w = 1'b0;
    upd_z = 1'b0;
    upd_cdc = 1'b0;
    upd_c = 1'b0;
    skip_chk = 1'b0;
    wdt_clr = 1'b0;
    case (instr[`LAU_F_GRP])
      `LAU_GRP_MISC: begin
        if (instr == `LAU_OPC_CLRWDT) begin
          wdt_clr = 1'b1;
        end else if (instr == `LAU_OPC_CLRW) begin
          alu_op = `LAU_OP_CLR;
          wr_w = 1'b1;
          upd_z = 1'b1;
        end else begin
          case (instr[`LAU_F_SUB])
            `LAU_SUB_CLRF: begin
              alu_op = `LAU_OP_CLR;
              wr_file = 1'b1;
              upd_z = 1'b1;
            end
            `LAU_SUB_SUBF: begin
              alu_op = `LAU_OP_SUB;
              wr_file = 1'b1;
              upd_z = 1'b1;
              upd_cdc = 1'b1;
            end
            `LAU_SUB_DECF: begin
              alu_op = `LAU_OP_DEC;
              wr_file = 1'b1;
              upd_z = 1'b1;
            end
            default: alu_op = `LAU_OP_PASS;
          endcase
        end
      end
      `LAU_GRP_LOGIC: begin
        // Destination bit: one writes the file, zero writes W
        wr_file = instr[`LAU_F_DST];
        wr_w = ~instr[`LAU_F_DST];
        upd_z = 1'b1;
        case (instr[`LAU_F_ALU])
          `LAU_LOG_OR: alu_op = `LAU_OP_OR;
          `LAU_LOG_AND: alu_op = `LAU_OP_AND;
          `LAU_LOG_XOR: alu_op = `LAU_OP_XOR;
          `LAU_LOG_ADD: begin
            alu_op = `LAU_OP_ADD;
            upd_cdc = 1'b1;
          end
          default: alu_op = `LAU_OP_PASS;
        endcase
      end
      `LAU_GRP_UNARY: begin
        case (instr[`LAU_F_SUB])
          `LAU_SUB_NOTF: begin
            alu_op = `LAU_OP_NOT;
            wr_file = 1'b1;
            upd_z = 1'b1;
          end
          `LAU_SUB_INCF: begin
            alu_op = `LAU_OP_INC;
            wr_file = 1'b1;
            upd_z = 1'b1;
          end
          `LAU_SUB_DEC_SKIP_ZERO: begin
            alu_op = `LAU_OP_DEC;
            wr_file = 1'b1;
            skip_chk = 1'b1;
          end
          default: alu_op = `LAU_OP_PASS;
        endcase
      end
      `LAU_GRP_SHIFT: begin
        case (instr[`LAU_F_SUB])
          `LAU_SUB_RRF: begin
            alu_op = `LAU_OP_RR;
            wr_file = 1'b1;
            upd_c = 1'b1;
          end
          `LAU_SUB_RLF: begin
            alu_op = `LAU_OP_RL;
            wr_file = 1'b1;
            upd_c = 1'b1;
          end
          `LAU_SUB_SWAPF: begin
            alu_op = `LAU_OP_SWAP;
            wr_file = 1'b1;
          end
          `LAU_SUB_INCSZ: begin
            alu_op = `LAU_OP_INC;
            wr_file = 1'b1;
            skip_chk = 1'b1;
          end
          default: alu_op = `LAU_OP_PASS;
        endcase
      end
      `LAU_GRP_ORLIT: begin
        alu_op = `LAU_OP_OR;
        use_lit = 1'b1;
        wr_w = 1'b1;
        upd_z = 1'b1;
      end
      `LAU_GRP_ANDLIT: begin
        alu_op = `LAU_OP_AND;
        use_lit = 1'b1;
        wr_w = 1'b1;
        upd_z = 1'b1;
      end
      `LAU_GRP_XORLIT: begin
        alu_op = `LAU_OP_XOR;
        use_lit = 1'b1;
        wr_w = 1'b1;
        upd_z = 1'b1;
      end
      default: alu_op = `LAU_OP_PASS;
    endcase
  end

  // Literal forms replace the file operand with the literal field
  assign alu_b = w_q;

  lau_alu u_alu (
    .op(alu_op),
    .a(use_lit ? instr[`LAU_F_LIT] : file_operand),
    .b(alu_b),
    .carry_flag(flags_q[`LAU_ST_C]),
    .carry_in_enable_n(carry_in_enable_n),
    .res(alu_res),
    .c_out(alu_c),
    .dc_out(alu_dc)
  );

  assign res_zero = (alu_res == `LAU_ZERO8);

  // Next flags: a write to 03h lands first, then the op's own flags win.
  // TO and PD stay read-only so software cannot fake a wake cause.
  always @* begin
    flags_d = flags_q;
    if (wr_file && file_addr == `LAU_ADDR_FLAGS) begin
      flags_d[`LAU_ST_PAGE] = alu_res[`LAU_ST_PAGE];
      flags_d[`LAU_ST_LOW] = alu_res[`LAU_ST_LOW];
    end
    if (upd_z) begin
      flags_d[`LAU_ST_Z] = res_zero;
    end
    if (upd_cdc) begin
      flags_d[`LAU_ST_C] = alu_c;
      flags_d[`LAU_ST_DC] = alu_dc;
    end
    if (upd_c) begin
      flags_d[`LAU_ST_C] = alu_c;
    end
    if (wdt_clr) begin
      flags_d[`LAU_ST_TO] = 1'b1;
      flags_d[`LAU_ST_PD] = 1'b1;
    end
  end

  // Next pointer and working register
  always @* begin
    fsel_d = fsel_q;
    if (wr_file && file_addr == `LAU_ADDR_FSEL) begin
      fsel_d = alu_res;
    end
    w_d = w_q;
    if (wr_w) begin
      w_d = alu_res;
    end
  end

  // Architectural state; everything moves only on a taken slot, except the skip, which a dropped slot clears
  always @(posedge mclk) begin
    if (rst) begin
      w_q <= `LAU_RST_W;
      flags_q <= `LAU_RST_FLAGS;
      fsel_q <= `LAU_RST_FSEL;
      skip_q <= 1'b0;
    end else if (take) begin
      w_q <= w_d;
      flags_q <= flags_d;
      fsel_q <= fsel_d;
      skip_q <= skip_chk & res_zero;
    end else if (drop) begin
      skip_q <= 1'b0;
    end
  end

  // File memory writes; special addresses and the indirect slot skip it.
  // No port here reaches option, watchdog or mode state.
  always @(posedge mclk) begin
    if (take && wr_file) begin
      case (file_addr)
        `LAU_ADDR_INDIRECT, `LAU_ADDR_PC_LOW,
        `LAU_ADDR_FLAGS, `LAU_ADDR_FSEL: begin
          file_mem[file_addr] <= file_mem[file_addr];
        end
        default: file_mem[file_addr] <= alu_res;
      endcase
    end
  end

  // One-cycle strobes: program counter load and watchdog clear.
  // The counter itself lives outside this unit, so only the pulse and its write data leave.
  always @(posedge mclk) begin
    if (rst) begin
      pc_wr_q <= 1'b0;
      pc_wdata_q <= `LAU_ZERO8;
      wdt_clear_q <= 1'b0;
      prescaler_clear_q <= 1'b0;
    end else begin
      pc_wr_q <= take & wr_file & (file_addr == `LAU_ADDR_PC_LOW);
      if (take && wr_file) begin
        pc_wdata_q <= alu_res;
      end
      wdt_clear_q <= take & wdt_clr;
      prescaler_clear_q <= take & wdt_clr & prescaler_to_wdt;
    end
  end

endmodule

// [logic/lau_regs.vh]
`ifndef LAU_REGS_VH
`define LAU_REGS_VH

// File register map
`define LAU_ADDR_INDIRECT 8'h00
`define LAU_ADDR_PC_LOW 8'h02
`define LAU_ADDR_FLAGS 8'h03
`define LAU_ADDR_FSEL 8'h04

// Condition flag bit positions
`define LAU_ST_C 0
`define LAU_ST_DC 1
`define LAU_ST_Z 2
`define LAU_ST_PD 3
`define LAU_ST_TO 4
`define LAU_ST_PAGE 7:5
`define LAU_ST_LOW 2:0

// Reset values
`define LAU_RST_FLAGS 8'h18
`define LAU_RST_W 8'h00
`define LAU_RST_FSEL 8'h00

// Instruction fields
`define LAU_IW 12
`define LAU_F_GRP 11:8
`define LAU_F_SUB 7:5
`define LAU_F_ALU 7:6
`define LAU_F_DST 5
`define LAU_F_FILE 4:0
`define LAU_F_BANKSEL 4
`define LAU_F_LIT 7:0
`define LAU_FSEL_BANK 7:5

// Opcode groups and sub-codes
`define LAU_GRP_MISC 4'h0
`define LAU_GRP_LOGIC 4'h1
`define LAU_GRP_UNARY 4'h2
`define LAU_GRP_SHIFT 4'h3
`define LAU_GRP_ORLIT 4'hd
`define LAU_GRP_ANDLIT 4'he
`define LAU_GRP_XORLIT 4'hf
`define LAU_OPC_CLRWDT 12'h004
`define LAU_OPC_CLRW 12'h040
`define LAU_SUB_CLRF 3'h3
`define LAU_SUB_SUBF 3'h5
`define LAU_SUB_DECF 3'h7
`define LAU_SUB_NOTF 3'h3
`define LAU_SUB_INCF 3'h5
`define LAU_SUB_DEC_SKIP_ZERO 3'h7
`define LAU_SUB_RRF 3'h1
`define LAU_SUB_RLF 3'h3
`define LAU_SUB_SWAPF 3'h5
`define LAU_SUB_INCSZ 3'h7
`define LAU_LOG_OR 2'h0
`define LAU_LOG_AND 2'h1
`define LAU_LOG_XOR 2'h2
`define LAU_LOG_ADD 2'h3

// Internal ALU operations
`define LAU_OP_W 4
`define LAU_OP_PASS 4'h0
`define LAU_OP_AND 4'h1
`define LAU_OP_OR 4'h2
`define LAU_OP_XOR 4'h3
`define LAU_OP_ADD 4'h4
`define LAU_OP_SUB 4'h5
`define LAU_OP_INC 4'h6
`define LAU_OP_DEC 4'h7
`define LAU_OP_RL 4'h8
`define LAU_OP_RR 4'h9
`define LAU_OP_SWAP 4'ha
`define LAU_OP_CLR 4'hb
`define LAU_OP_NOT 4'hc

// Data constants and instruction-rate divide factors
`define LAU_ZERO8 8'h00
`define LAU_ONES8 8'hff
`define LAU_DIV_TURBO 1
`define LAU_DIV_COMPAT 4

`endif

// [logic/lau_alu.v]
`timescale 1ns/1ps
`include "lau_regs.vh"

module lau_alu (
  input wire [`LAU_OP_W-1:0] op,
  input wire [7:0] a,
  input wire [7:0] b,
  input wire carry_flag,
  input wire carry_in_enable_n,
  output reg [7:0] res,
  output reg c_out,
  output reg dc_out
);

  reg [7:0] add_b;
  reg add_cin;
  reg [4:0] lo_sum;
  reg [8:0] sum;

  // One shared adder serves add, subtract, increment and decrement
  always @* begin
    add_b = b;
    add_cin = 1'b0;
    case (op)
      `LAU_OP_ADD: begin
        add_cin = ~carry_in_enable_n & carry_flag;
      end
      `LAU_OP_SUB: begin
        add_b = ~b;
        // Borrow-in is the inverted carry; with carry-in off, plain a - b
        add_cin = carry_in_enable_n | carry_flag;
      end
      `LAU_OP_INC: begin
        add_b = `LAU_ZERO8;
        add_cin = 1'b1;
      end
      `LAU_OP_DEC: begin
        add_b = `LAU_ONES8;
      end
      default: begin
        add_b = b;
      end
    endcase
    lo_sum = {1'b0, a[3:0]} + {1'b0, add_b[3:0]} + {4'h0, add_cin};
    sum = {1'b0, a} + {1'b0, add_b} + {8'h00, add_cin};
  end

  // Result and carry outputs; carry reads as not-borrow on subtract
  always @* begin
    res = a;
    c_out = carry_flag;
    dc_out = lo_sum[4];
    case (op)
      `LAU_OP_AND: res = a & b;
      `LAU_OP_OR: res = a | b;
      `LAU_OP_XOR: res = a ^ b;
      `LAU_OP_ADD, `LAU_OP_SUB: begin
        res = sum[7:0];
        c_out = sum[8];
      end
      `LAU_OP_INC, `LAU_OP_DEC: res = sum[7:0];
      `LAU_OP_RL: begin
        res = {a[6:0], carry_flag};
        c_out = a[7];
      end
      `LAU_OP_RR: begin
        res = {carry_flag, a[7:1]};
        c_out = a[0];
      end
      `LAU_OP_SWAP: res = {a[3:0], a[7:4]};
      `LAU_OP_CLR: res = `LAU_ZERO8;
      `LAU_OP_NOT: res = a ^ `LAU_ONES8;
      default: res = a;
    endcase
  end

endmodule

// [logic/lau_rate_div.v]
`timescale 1ns/1ps
`include "lau_regs.vh"

module lau_rate_div #(
  parameter CNT_W = 2
) (
  input wire mclk,
  input wire rst,
  input wire turbo_mode,
  output reg slot_q
);

  reg [CNT_W-1:0] cnt_q;

  // Instruction slot strobe: every clock, or every fourth clock
  always @(posedge mclk) begin
    if (rst) begin
      cnt_q <= {CNT_W{1'b0}};
      slot_q <= 1'b0;
    end else begin
      cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
      if (turbo_mode) begin
        slot_q <= 1'b1;
      end else begin
        slot_q <= (cnt_q == (`LAU_DIV_COMPAT - 1));
      end
    end
  end

endmodule

// [verification/lau_core_monitor.sv]
`timescale 1ns/1ps
// Watches the instruction port and the state the core drives back
module lau_core_monitor (
  input wire mclk,
  input wire rst,
  input wire turbo_mode,
  input wire prescaler_to_wdt,
  input wire [11:0] instr,
  input wire instr_valid,
  input wire slot_q,
  input wire [7:0] w_q,
  input wire [7:0] flags_q,
  input wire [7:0] fsel_q,
  input wire pc_wr_q,
  input wire [7:0] pc_wdata_q,
  input wire skip_q,
  input wire wdt_clear_q,
  input wire prescaler_clear_q
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // Instruction accepted at this edge, and its upper opcode bits
  wire take = slot_q && instr_valid && !skip_q;
  wire [6:0] op7 = instr[11:5];

  idle_hold_a:
    assert property (!(slot_q && instr_valid) |=> $stable(w_q) && $stable(flags_q)
      && $stable(fsel_q)) else $error("state moved with no instruction");
  slot_turbo_a:
    assert property (turbo_mode && !$past(rst) |-> slot_q) else $error("turbo slot missing");
  slot_compat_a:
    assert property (!turbo_mode && slot_q |=> !slot_q [*3] ##1 slot_q)
      else $error("compatible slot spacing wrong");
  wdt_clear_a:
    assert property (take && instr == 12'h004 |=> wdt_clear_q && flags_q[4:3] == 2'b11)
      else $error("watchdog clear wrong");
  presc_clear_a:
    assert property (wdt_clear_q |-> prescaler_clear_q == $past(prescaler_to_wdt))
      else $error("prescaler clear wrong");
  swap_flags_a:
    assert property (take && op7 == 7'h1d |=> $stable(flags_q)) else $error("swap moved flags");
  skip_flags_a:
    assert property (take && (op7 == 7'h17 || op7 == 7'h1f) |=> $stable(flags_q))
      else $error("skip op moved flags");
  skip_drop_a:
    assert property (slot_q && instr_valid && skip_q |=> !skip_q && $stable(w_q)
      && $stable(flags_q)) else $error("skipped op not dropped");
  rot_flags_a:
    assert property (take && (op7 == 7'h19 || op7 == 7'h1b) |=>
      flags_q[7:1] == $past(flags_q[7:1])) else $error("rotate moved other flags");
  lit_zero_a:
    assert property (take && instr[11:8] >= 4'hd |=> flags_q[2] == (w_q == 8'h00)
      && flags_q[1:0] == $past(flags_q[1:0])) else $error("literal op zero flag wrong");
  clr_w_a:
    assert property (take && instr == 12'h040 |=> w_q == 8'h00 && flags_q[2])
      else $error("clear accumulator wrong");
  pc_write_a:
    assert property (take && instr == 12'h062 |=> pc_wr_q && pc_wdata_q == 8'h00)
      else $error("program counter write wrong");
endmodule

// [verification/test_lau_core.sv]
`timescale 1ns/1ps
// Bench drives the core's instruction port directly
module test_lau_core;
  reg mclk = 1'b0;
  reg rst = 1'b1;
  reg turbo_mode = 1'b1;
  reg carry_in_enable_n = 1'b1;
  reg prescaler_to_wdt = 1'b1;
  reg [11:0] instr = 12'h000;
  reg instr_valid = 1'b0;
  reg [7:0] pc_low_in = 8'h5c;
  wire slot_q, pc_wr_q, skip_q, wdt_clear_q, prescaler_clear_q;
  wire [7:0] w_q, flags_q, fsel_q, pc_wdata_q;
  integer fails = 0;
  integer checks = 0;
  integer n;

  // 40 MHz core clock
  always #12.5 mclk = ~mclk;

  lau_core i_dut (.mclk(mclk), .rst(rst), .turbo_mode(turbo_mode),
    .carry_in_enable_n(carry_in_enable_n), .prescaler_to_wdt(prescaler_to_wdt),
    .instr(instr), .instr_valid(instr_valid), .pc_low_in(pc_low_in), .slot_q(slot_q),
    .w_q(w_q), .flags_q(flags_q), .fsel_q(fsel_q), .pc_wr_q(pc_wr_q),
    .pc_wdata_q(pc_wdata_q), .skip_q(skip_q), .wdt_clear_q(wdt_clear_q),
    .prescaler_clear_q(prescaler_clear_q));

  task chk8(input [7:0] got, input [7:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask

  task chk1(input got, input exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask

  task give_verdict;
    begin
      $display("checks=%0d fails=%0d", checks, fails);
      if (fails == 0 && checks > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask

  // Hold the word until a slot takes it; valid stays up so the next call never toggles it
  task exec(input [11:0] op);
    integer k;
    begin
      instr = op;
      instr_valid = 1'b1;
      k = 0;
      while (slot_q !== 1'b1 && k < 8) begin
        k = k + 1;
        @(negedge mclk);
      end
      // A slot that never comes is a hang, counted as a mismatch
      if (slot_q !== 1'b1)
        fails = fails + 1;
      @(negedge mclk);
    end
  endtask

  task setw(input [7:0] v);
    begin
      exec(12'h040);
      exec({4'hd, v});
    end
  endtask

  // File writes go through W since no move is in this core
  task setf(input [4:0] f, input [7:0] v);
    begin
      setw(v);
      exec({7'h03, f});
      exec({7'h09, f});
    end
  endtask

  task rdf(input [4:0] f);
    begin
      exec(12'h040);
      exec({7'h08, f});
    end
  endtask

  // One operation on file 08h = a5h with W = 3ch
  task op(input [11:0] o, input to_f, input [7:0] exp, input [2:0] m, input [2:0] fl);
    begin
      setf(5'h08, 8'ha5);
      setw(8'h3c);
      exec(o);
      chk8({5'h00, flags_q[2:0] & m}, {5'h00, fl & m});
      if (to_f)
        rdf(5'h08);
      chk8(w_q, exp);
    end
  endtask

  // Skip op on file 09h, then a clear of W that is dropped when skipping
  task skp(input [11:0] o, input [7:0] v, input [7:0] r, input s);
    begin
      setf(o[4:0], v);
      exec(o);
      chk1(skip_q, s);
      exec(12'h040);
      chk8(w_q, s ? v : 8'h00);
      rdf(o[4:0]);
      chk8(w_q, r);
    end
  endtask

  task rst_seq;
    begin
      rst = 1'b1;
      instr_valid = 1'b0;
      repeat (12) @(negedge mclk);
      chk8(w_q, 8'h00);
      chk8(fsel_q, 8'h00);
      chk8(flags_q, 8'h18);
      rst = 1'b0;
    end
  endtask

  // Main sequence
  initial begin
    rst_seq;
    op(12'h168, 1, 8'h24, 3'h4, 3'h0);
    op(12'h148, 0, 8'h24, 3'h4, 3'h0);
    op(12'he5a, 0, 8'h18, 3'h4, 3'h0);
    op(12'h128, 1, 8'hbd, 3'h4, 3'h0);
    op(12'h108, 0, 8'hbd, 3'h4, 3'h0);
    op(12'hdc3, 0, 8'hff, 3'h4, 3'h0);
    op(12'h1a8, 1, 8'h99, 3'h4, 3'h0);
    op(12'h188, 0, 8'h99, 3'h4, 3'h0);
    op(12'hf3c, 0, 8'h00, 3'h4, 3'h4);
    op(12'h268, 1, 8'h5a, 3'h4, 3'h0);
    op(12'h068, 1, 8'h00, 3'h4, 3'h4);
    op(12'h040, 0, 8'h00, 3'h4, 3'h4);
    op(12'h0e8, 1, 8'ha4, 3'h4, 3'h0);
    op(12'h2a8, 1, 8'ha6, 3'h4, 3'h0);
    op(12'h3a8, 1, 8'h5a, 3'h4, 3'h0);
    op(12'h1e8, 1, 8'he1, 3'h7, 3'h2);
    op(12'h1c8, 0, 8'he1, 3'h7, 3'h2);
    op(12'h0a8, 1, 8'h69, 3'h7, 3'h1);
    op(12'h368, 1, 8'h4b, 3'h1, 3'h1);
    op(12'h328, 1, 8'hd2, 3'h1, 3'h1);
    skp(12'h3e9, 8'hff, 8'h00, 1'b1);
    skp(12'h2e9, 8'h05, 8'h04, 1'b0);
    skp(12'h2e9, 8'h01, 8'h00, 1'b1);
    // Carry joins add and subtract; carry is still set by the rotates
    carry_in_enable_n = 1'b0;
    setf(5'h08, 8'h10);
    setw(8'h20);
    exec(12'h1c8);
    chk8(w_q, 8'h31);
    chk8({5'h00, flags_q[2:0]}, 8'h00);
    setf(5'h08, 8'h50);
    setw(8'h10);
    exec(12'h0a8);
    chk8({5'h00, flags_q[2:0]}, 8'h01);
    rdf(5'h08);
    chk8(w_q, 8'h3f);
    carry_in_enable_n = 1'b1;
    exec(12'h004);
    chk1(wdt_clear_q, 1'b1);
    chk1(prescaler_clear_q, 1'b1);
    chk8({6'h00, flags_q[4:3]}, 8'h03);
    prescaler_to_wdt = 1'b0;
    exec(12'h004);
    chk1(prescaler_clear_q, 1'b0);
    exec(12'h062);
    chk1(pc_wr_q, 1'b1);
    chk8(pc_wdata_q, 8'h00);
    rdf(5'h02);
    chk8(w_q, 8'h5c);
    setw(8'he0);
    exec(12'h123);
    chk8({5'h00, flags_q[7:5]}, 8'h07);
    setf(5'h04, 8'h08);
    chk8(fsel_q, 8'h08);
    setw(8'h5a);
    exec(12'h060);
    exec(12'h120);
    rdf(5'h08);
    chk8(w_q, 8'h5a);
    // Banked direct access: f 10h lands at 70h, read back through the pointer
    setf(5'h04, 8'h70);
    setw(8'h33);
    exec(12'h070);
    exec(12'h130);
    rdf(5'h00);
    chk8(w_q, 8'h33);
    // Second reset into the quarter-rate mode
    turbo_mode = 1'b0;
    rst_seq;
    op(12'h1e8, 1, 8'he1, 3'h7, 3'h2);
    instr_valid = 1'b0;
    n = 0;
    repeat (16) begin
      @(negedge mclk);
      n = n + slot_q;
    end
    chk8(n[7:0], 8'h04);
    give_verdict;
  end

  // Hang guard, far beyond the few hundred cycles the tests need
  initial begin
    #(25 * 20000);
    fails = fails + 1;
    give_verdict;
  end
endmodule

bind lau_core lau_core_monitor i_mon (.mclk(mclk), .rst(rst), .turbo_mode(turbo_mode),
  .prescaler_to_wdt(prescaler_to_wdt), .instr(instr), .instr_valid(instr_valid),
  .slot_q(slot_q), .w_q(w_q), .flags_q(flags_q), .fsel_q(fsel_q), .pc_wr_q(pc_wr_q),
  .pc_wdata_q(pc_wdata_q), .skip_q(skip_q), .wdt_clear_q(wdt_clear_q),
  .prescaler_clear_q(prescaler_clear_q));
